// ===== design/dsco_top.sv
// DIO sample/change service: register port, sample queue, reports, bound output updates
// Registers on a plain strobe port; rx and adc inputs come from logic on ref_clk_in
// Operation
// (R01) Received packets change outputs only when their source equals the bound address.
// (R02) Bound address is writable and readable as short 16-bit or long 64-bit.
// (R03) Bound address of all ones blocks every received packet from changing outputs.
// (R04) Short bound address of all ones accepts packets from any sender.
// (R05) Eight-bit change mask, bit n enables change watch on line n.
// (R06) Change mask resets to zero, every line unwatched.
// (R07) A change report carries digital line data only, no analog part.
// (R08) Queued samples are sent before a change report.
// (R09) Output-level bitmap drives each output line to its bit.
// (R10) With an interval set, enabled lines are sampled once per interval.
// (R11) Interval is a 16-bit count of milliseconds.
// (R12) Exact millisecond timing is not guaranteed when sending every sample.
// (R13) Software should avoid intervals needing transmissions faster than every 20 ms.
// (R14) A set number of samples is collected before one report goes out.
// (R15) Zero interval stops sampling; the interval timer restarts after each sample.
// (R16) Level bits of lines not set as outputs have no effect.
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "dsco_defines.svh"
module dsco_top
#(
   parameter int CYC_PER_MS = `DSCO_CYC_PER_MS
)
(
   // Clock, reset, enable
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   // Register port
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   // Digital lines
   input wire logic [7:0] dio_in,
   output logic [7:0] dio_out,
   output logic [7:0] dio_oe_out,
   // Analog sample word
   input wire logic [9:0] adc_in,
   // Received I/O packets
   input wire logic rx_valid_in,
   input wire logic rx_long_in,
   input wire logic [63:0] rx_src_in,
   input wire dsco_pkg::dsco_byte_t rx_levels_in,
   // Report stream
   output dsco_pkg::dsco_word_t rpt_word_out,
   output logic rpt_valid_out,
   output logic rpt_last_out,
   output logic rpt_dio_only_out,
   input wire logic rpt_ready_in,
   // Interrupt
   output logic irq_out
);
   import dsco_pkg::*;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   dsco_link_if lk();
   dsco_pin_watch u_watch (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .dio_in(dio_in), .lk(lk));
   dsco_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_tmr (.ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in), .lk(lk));

   logic [63:0] bia_reg;
   logic bia_long_reg;
   logic [7:0] chg_mask_reg;
   logic [7:0] lvl_reg;
   logic [7:0] dir_reg;
   logic [15:0] interval_reg;
   logic [7:0] spr_reg;
   logic adc_en_reg;
   logic [3:0] irq_stat_reg;
   logic [3:0] irq_mask_reg;
   logic [31:0] rdata_reg;
   logic irq_reg;
   logic [7:0] dio_reg;
   logic [7:0] oe_reg;
   dsco_word_t q_mem [0:`DSCO_QDEPTH-1];
   logic [5:0] q_cnt_reg;
   logic [5:0] rd_idx_reg;
   logic flush_pend_reg;
   logic chg_pend_reg;
   logic [7:0] chg_word_reg;
   dsco_state_t st_reg;
   dsco_word_t word_reg;
   logic valid_reg;
   logic last_reg;
   logic dio_only_reg;

   wire ce = clk_en_in;
   wire wr_lo = wr_in && hit(addr_in, `DSCO_OFF_BIA_LO);
   wire wr_hi = wr_in && hit(addr_in, `DSCO_OFF_BIA_HI);
   wire wr_mode = wr_in && hit(addr_in, `DSCO_OFF_BIA_MODE);
   wire wr_lvl = wr_in && hit(addr_in, `DSCO_OFF_OUT_LEVEL);
   wire wr_w1c = wr_in && hit(addr_in, `DSCO_OFF_IRQ_STAT);

   // Bound-address acceptance of received packets
   wire bia_blocked = bia_long_reg && (&bia_reg); // R03
   wire bia_any = !bia_long_reg && (bia_reg[15:0] == `DSCO_BIA_SHORT_ANY); // R04
   wire src_long_eq = rx_long_in && (rx_src_in == bia_reg);
   wire src_short_eq = !rx_long_in && (rx_src_in[15:0] == bia_reg[15:0]);
   wire src_match = bia_long_reg ? src_long_eq : src_short_eq;
   wire rx_accept = rx_valid_in && !bia_blocked && (bia_any || src_match); // R01

   // Effective samples per report, kept within the queue depth
   wire [5:0] spr_eff = (spr_reg == 8'h00) ? 6'd1 :
      (spr_reg > 8'(`DSCO_QDEPTH)) ? 6'(`DSCO_QDEPTH) : spr_reg[5:0];
   wire [7:0] in_lines = lk.pins & ~dir_reg;
   wire [9:0] adc_part = adc_en_reg ? adc_in : 10'h000;
   // A pending change report also drops the sample, so nothing queued can trail the change word
   wire take = lk.sample && (st_reg == DSCO_IDLE) && !flush_pend_reg && !chg_pend_reg &&
      (q_cnt_reg < spr_eff); // R12
   wire can_load = !valid_reg || rpt_ready_in;
   wire rpt_done = valid_reg && rpt_ready_in && last_reg;
   wire [3:0] ev = {rpt_done, rx_valid_in && !rx_accept, rx_accept, lk.change};
   wire [3:0] stat_next = (irq_stat_reg & ~(wr_w1c ? wdata_in[3:0] : 4'h0)) | ev;

   wire [31:0] rd_mux =
      hit(addr_in, `DSCO_OFF_BIA_LO) ? bia_reg[31:0] :
      hit(addr_in, `DSCO_OFF_BIA_HI) ? bia_reg[63:32] :
      hit(addr_in, `DSCO_OFF_BIA_MODE) ? {31'h0, bia_long_reg} :
      hit(addr_in, `DSCO_OFF_CHG_MASK) ? {24'h0, chg_mask_reg} :
      hit(addr_in, `DSCO_OFF_OUT_LEVEL) ? {24'h0, lvl_reg} :
      hit(addr_in, `DSCO_OFF_OUT_DIR) ? {24'h0, dir_reg} :
      hit(addr_in, `DSCO_OFF_INTERVAL) ? {16'h0, interval_reg} :
      hit(addr_in, `DSCO_OFF_SPR) ? {24'h0, spr_reg} :
      hit(addr_in, `DSCO_OFF_PIN_STATE) ? {24'h0, lk.pins} :
      hit(addr_in, `DSCO_OFF_IRQ_STAT) ? {28'h0, irq_stat_reg} :
      hit(addr_in, `DSCO_OFF_IRQ_MASK) ? {28'h0, irq_mask_reg} :
      hit(addr_in, `DSCO_OFF_QUEUE) ? {16'h0, 6'h0, st_reg, 2'h0, q_cnt_reg} :
      hit(addr_in, `DSCO_OFF_ADC_EN) ? {31'h0, adc_en_reg} : 32'h0000_0000;

   assign lk.ce = ce;
   assign lk.mask = chg_mask_reg;
   assign lk.interval = interval_reg;

   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         bia_reg <= `DSCO_BIA_RST;
         bia_long_reg <= 1'b1;
      end
      else if (ce)
      begin
         if (wr_lo)
            bia_reg[31:0] <= wdata_in; // R02
         if (wr_hi)
            bia_reg[63:32] <= wdata_in; // R02
         if (wr_mode)
            bia_long_reg <= wdata_in[0]; // R02
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         chg_mask_reg <= `DSCO_CHG_MASK_RST; // R06
         dir_reg <= 8'h00;
         interval_reg <= `DSCO_INTERVAL_RST;
         spr_reg <= `DSCO_SPR_RST;
         irq_mask_reg <= 4'h0;
         adc_en_reg <= 1'b0;
      end
      else if (ce && wr_in)
      begin
         if (hit(addr_in, `DSCO_OFF_CHG_MASK))
            chg_mask_reg <= wdata_in[7:0]; // R05
         if (hit(addr_in, `DSCO_OFF_OUT_DIR))
            dir_reg <= wdata_in[7:0];
         if (hit(addr_in, `DSCO_OFF_INTERVAL))
            interval_reg <= wdata_in[15:0]; // R11
         if (hit(addr_in, `DSCO_OFF_SPR))
            spr_reg <= wdata_in[7:0]; // R14
         if (hit(addr_in, `DSCO_OFF_IRQ_MASK))
            irq_mask_reg <= wdata_in[3:0];
         if (hit(addr_in, `DSCO_OFF_ADC_EN))
            adc_en_reg <= wdata_in[0];
      end
   end

   // A software write wins over a packet arriving in the same cycle
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
         lvl_reg <= 8'h00;
      else if (ce && wr_lvl)
         lvl_reg <= wdata_in[7:0]; // R09
      else if (ce && rx_accept)
         lvl_reg <= rx_levels_in; // R01
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         dio_reg <= 8'h00;
         oe_reg <= 8'h00;
      end
      else if (ce)
      begin
         dio_reg <= lvl_reg & dir_reg; // R16
         oe_reg <= dir_reg; // R09
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         irq_stat_reg <= 4'h0;
         irq_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end
      else if (ce)
      begin
         irq_stat_reg <= stat_next;
         irq_reg <= |(stat_next & irq_mask_reg);
         rdata_reg <= rd_in ? rd_mux : 32'h0000_0000;
      end
   end

   // Queue memory; a sample that arrives while a report is in flight is dropped
   always_ff @(posedge ref_clk_in)
   begin
      if (ce && take)
         q_mem[q_cnt_reg] <= {adc_part, in_lines}; // R10
   end

   // Change requests: a new change in the cycle the pending one is taken wins
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         chg_pend_reg <= 1'b0;
         chg_word_reg <= 8'h00;
      end
      else if (ce)
      begin
         if (lk.change)
         begin
            chg_pend_reg <= 1'b1;
            chg_word_reg <= lk.pins;
         end
         else if (st_reg == DSCO_CHG)
            chg_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         st_reg <= DSCO_IDLE;
         q_cnt_reg <= 6'd0;
         rd_idx_reg <= 6'd0;
         flush_pend_reg <= 1'b0;
         word_reg <= '0;
         valid_reg <= 1'b0;
         last_reg <= 1'b0;
         dio_only_reg <= 1'b0;
      end
      else if (ce)
      begin
         unique case (st_reg)
            DSCO_IDLE:
            begin
               rd_idx_reg <= 6'd0;
               if (take)
               begin
                  q_cnt_reg <= q_cnt_reg + 6'd1;
                  flush_pend_reg <= (q_cnt_reg + 6'd1 == spr_eff); // R14
               end
               if (flush_pend_reg || (chg_pend_reg && q_cnt_reg != 6'd0))
                  st_reg <= DSCO_FLUSH; // R08
               else if (chg_pend_reg)
                  st_reg <= DSCO_CHG;
            end
            DSCO_FLUSH:
            begin
               if (can_load && rd_idx_reg < q_cnt_reg)
               begin
                  word_reg <= q_mem[rd_idx_reg];
                  valid_reg <= 1'b1;
                  last_reg <= (rd_idx_reg + 6'd1 == q_cnt_reg);
                  dio_only_reg <= 1'b0;
                  rd_idx_reg <= rd_idx_reg + 6'd1;
               end
               else if (can_load)
               begin
                  valid_reg <= 1'b0;
                  q_cnt_reg <= 6'd0;
                  flush_pend_reg <= 1'b0;
                  st_reg <= chg_pend_reg ? DSCO_CHG : DSCO_IDLE; // R08
               end
            end
            DSCO_CHG:
            begin
               word_reg <= {10'h000, chg_word_reg}; // R07
               valid_reg <= 1'b1;
               last_reg <= 1'b1;
               dio_only_reg <= 1'b1; // R07
               st_reg <= DSCO_DRAIN;
            end
            DSCO_DRAIN:
            begin
               if (rpt_ready_in)
               begin
                  valid_reg <= 1'b0;
                  st_reg <= DSCO_IDLE;
               end
            end
         endcase
      end
   end

   assign rdata_out = rdata_reg;
   assign irq_out = irq_reg;
   assign dio_out = dio_reg;
   assign dio_oe_out = oe_reg;
   assign rpt_word_out = word_reg;
   assign rpt_valid_out = valid_reg;
   assign rpt_last_out = last_reg;
   assign rpt_dio_only_out = dio_only_reg;

   sequence s_rx_taken;
      ce && rx_valid_in && !wr_lvl;
   endsequence

   property p_rx_match;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      s_rx_taken and (src_match && !bia_blocked) |=> lvl_reg == $past(rx_levels_in);
   endproperty
   a_rx_match: assert property (p_rx_match) else $error("matched packet not applied"); // R01

   property p_rx_block;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      s_rx_taken and bia_blocked |=> $stable(lvl_reg) ##1 $stable(dio_out);
   endproperty
   a_rx_block: assert property (p_rx_block) else $error("blocked packet changed outputs"); // R03

   property p_rx_any;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      s_rx_taken and bia_any |=> lvl_reg == $past(rx_levels_in);
   endproperty
   a_rx_any: assert property (p_rx_any) else $error("open bound address refused packet"); // R04

   property p_mask_rst;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      $rose(rst_n_in) |-> chg_mask_reg == 8'h00 && !lk.change;
   endproperty
   a_mask_rst: assert property (p_mask_rst) else $error("change mask not cleared"); // R06

   property p_chg_only;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      ce && st_reg == DSCO_CHG |=> rpt_valid_out && rpt_dio_only_out && rpt_word_out[17:8] == 10'h0;
   endproperty
   a_chg_only: assert property (p_chg_only) else $error("change report has analog data"); // R07

   sequence s_chg_with_queue;
      ce && st_reg == DSCO_IDLE && chg_pend_reg && q_cnt_reg != 6'd0;
   endsequence

   property p_flush_first;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      s_chg_with_queue |=> st_reg == DSCO_FLUSH;
   endproperty
   a_flush_first: assert property (p_flush_first) else $error("change sent before queue"); // R08

   property p_out_lvl;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      ce && wr_lvl ##1 ce |=> dio_out == ($past(wdata_in[7:0], 2) & dio_oe_out);
   endproperty
   a_out_lvl: assert property (p_out_lvl) else $error("output level not driven"); // R16

   property p_no_sample;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      (interval_reg == 16'h0000)[*2] |-> !lk.sample;
   endproperty
   a_no_sample: assert property (p_no_sample) else $error("sample with zero interval"); // R15

   property p_take;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      ce && take |=> q_cnt_reg == $past(q_cnt_reg) + 6'd1;
   endproperty
   a_take: assert property (p_take) else $error("sample not queued"); // R10

   property p_full;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      ce && take && (q_cnt_reg + 6'd1 == spr_eff) |=> flush_pend_reg ##1 st_reg == DSCO_FLUSH;
   endproperty
   a_full: assert property (p_full) else $error("report not started at count"); // R14
endmodule

// ===== design/dsco_defines.svh
// Offsets, field positions, reset values and timing counts for the DIO sample/change block
// Included by the top module of the block only; definitions only
`ifndef DSCO_DEFINES_SVH
`define DSCO_DEFINES_SVH
`define DSCO_OFF_BIA_LO 8'h00
`define DSCO_OFF_BIA_HI 8'h04
`define DSCO_OFF_BIA_MODE 8'h08
`define DSCO_OFF_CHG_MASK 8'h0C
`define DSCO_OFF_OUT_LEVEL 8'h10
`define DSCO_OFF_OUT_DIR 8'h14
`define DSCO_OFF_INTERVAL 8'h18
`define DSCO_OFF_SPR 8'h1C
`define DSCO_OFF_PIN_STATE 8'h20
`define DSCO_OFF_IRQ_STAT 8'h24
`define DSCO_OFF_IRQ_MASK 8'h28
`define DSCO_OFF_QUEUE 8'h2C
`define DSCO_OFF_ADC_EN 8'h30
`define DSCO_BIA_RST 64'hFFFF_FFFF_FFFF_FFFF
`define DSCO_BIA_SHORT_ANY 16'hFFFF
`define DSCO_CHG_MASK_RST 8'h00
`define DSCO_SPR_RST 8'h01
`define DSCO_INTERVAL_RST 16'h0000
`define DSCO_QDEPTH 46
`define DSCO_IRQ_CHANGE 0
`define DSCO_IRQ_RX_APPLY 1
`define DSCO_IRQ_RX_REJECT 2
`define DSCO_IRQ_REPORT 3
`define DSCO_MS_NS 1000000
`define DSCO_CLK_NS 40
`define DSCO_CYC_PER_MS (`DSCO_MS_NS / `DSCO_CLK_NS)
`endif

// ===== design/dsco_pkg.sv
// Types shared by the DIO sample/change block
// No assumptions beyond a SystemVerilog compiler
package dsco_pkg;
   typedef logic [17:0] dsco_word_t;
   typedef logic [7:0] dsco_byte_t;
   typedef enum logic [1:0] {DSCO_IDLE, DSCO_FLUSH, DSCO_CHG, DSCO_DRAIN} dsco_state_t;
endpackage

// ===== design/dsco_link_if.sv
// Carrier between the core and its pin-watch and interval-timer helpers
// All members live on ref_clk_in
`timescale 1ns/1ps
interface dsco_link_if;
   logic ce;
   logic [7:0] pins;
   logic [7:0] mask;
   logic change;
   logic [15:0] interval;
   logic sample;
   modport core(output ce, mask, interval, input pins, change, sample);
   modport watch(input ce, mask, output pins, change);
   modport tmr(input ce, interval, output sample);
endinterface

// ===== design/dsco_pin_watch.sv
// Synchronises the eight digital lines and flags a change on any monitored line
// Lines are asynchronous pins; mask comes from the core on the same clock
`timescale 1ns/1ps
module dsco_pin_watch
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Pins and core link
   input wire logic [7:0] dio_in,
   dsco_link_if.watch lk
);
   logic [7:0] meta_reg;
   logic [7:0] sync_reg;
   logic [7:0] prev_reg;
   logic change_reg;
   wire [7:0] diff = (sync_reg ^ prev_reg) & lk.mask;

   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1)
      begin : g_line
         always_ff @(posedge ref_clk_in)
         begin
            if (!rst_n_in)
            begin
               meta_reg[i] <= 1'b0;
               sync_reg[i] <= 1'b0;
               prev_reg[i] <= 1'b0;
            end
            else if (lk.ce)
            begin
               meta_reg[i] <= dio_in[i];
               sync_reg[i] <= meta_reg[i];
               prev_reg[i] <= sync_reg[i];
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
         change_reg <= 1'b0;
      else if (lk.ce)
         change_reg <= |diff; // R05
   end

   assign lk.pins = sync_reg;
   assign lk.change = change_reg;
endmodule

// ===== design/dsco_ms_timer.sv
// Millisecond prescaler and sample-interval counter
// The interval value is held in the core; a zero interval stops sampling
`timescale 1ns/1ps
module dsco_ms_timer
#(
   parameter int CYC_PER_MS = 25000
)
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Core link
   dsco_link_if.tmr lk
);
   localparam int PW = $clog2(CYC_PER_MS);
   logic [PW-1:0] pre_reg;
   logic [15:0] ms_reg;
   logic sample_reg;
   wire ms_tick = (pre_reg == PW'(CYC_PER_MS - 1));
   wire due = (ms_reg + 16'h0001 >= lk.interval);

   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
         pre_reg <= '0;
      else if (lk.ce)
         pre_reg <= ms_tick ? '0 : pre_reg + 1'b1; // R11
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         ms_reg <= 16'h0000;
         sample_reg <= 1'b0;
      end
      else if (lk.ce)
      begin
         sample_reg <= 1'b0;
         if (lk.interval == 16'h0000)
            ms_reg <= 16'h0000; // R15
         else if (ms_tick && due)
         begin
            ms_reg <= 16'h0000; // R15
            sample_reg <= 1'b1; // R10
         end
         else if (ms_tick)
            ms_reg <= ms_reg + 16'h0001;
      end
   end

   assign lk.sample = sample_reg;
endmodule

// ===== verification/dsco_far_model.sv
// Report sink standing where the radio transmit path would take reports
// Lives on ref_clk_in; slow_in makes ready drop every other cycle to stall the stream
`timescale 1ns/1ps
module dsco_far_model
(
   // Clock and mode
   input wire logic ref_clk_in,
   input wire logic slow_in,
   // Report stream
   input wire dsco_pkg::dsco_word_t rpt_word_in,
   input wire logic rpt_valid_in,
   input wire logic rpt_last_in,
   input wire logic rpt_dio_only_in,
   output logic rpt_ready_out
);
   import dsco_pkg::*;
   logic [19:0] log_q[$];
   logic phase = 1'b0;
   initial rpt_ready_out = 1'b0;
   // Words are logged only on a real handshake, so a held word counts once
   always @(posedge ref_clk_in)
   begin
      phase <= ~phase;
      rpt_ready_out <= ~slow_in | phase;
      if (rpt_valid_in && rpt_ready_out)
      begin
         log_q.push_back({rpt_dio_only_in, rpt_last_in, rpt_word_in});
      end
   end
endmodule

// ===== verification/dsco_top_test.sv
// Self-checking bench for the DIO sample/change block
// Drives register port, pins, analog word and received packets; the far model sinks reports
`timescale 1ns/1ps
module dsco_top_test;
   import dsco_pkg::*;
   localparam int CPM = 10;
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [31:0] wdata_in = 32'h0;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [31:0] rdata_out;
   logic [7:0] dio_in = 8'h00;
   logic [7:0] dio_out;
   logic [7:0] dio_oe_out;
   logic [9:0] adc_in = 10'h000;
   logic rx_valid_in = 1'b0;
   logic rx_long_in = 1'b0;
   logic [63:0] rx_src_in = 64'h0;
   dsco_byte_t rx_levels_in = 8'h00;
   dsco_word_t rpt_word_out;
   logic rpt_valid_out, rpt_last_out, rpt_dio_only_out, rpt_ready_in, irq_out;
   logic slow = 1'b0;
   logic clk_en_in = 1'b1;
   int mismatches = 0;
   int num_checks = 0;

   always #20 ref_clk_in = ~ref_clk_in;

   dsco_top #(.CYC_PER_MS(CPM)) dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .clk_en_in(clk_en_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .dio_in(dio_in), .dio_out(dio_out), .dio_oe_out(dio_oe_out),
      .adc_in(adc_in), .rx_valid_in(rx_valid_in), .rx_long_in(rx_long_in),
      .rx_src_in(rx_src_in), .rx_levels_in(rx_levels_in), .rpt_word_out(rpt_word_out),
      .rpt_valid_out(rpt_valid_out), .rpt_last_out(rpt_last_out),
      .rpt_dio_only_out(rpt_dio_only_out), .rpt_ready_in(rpt_ready_in), .irq_out(irq_out));

   dsco_far_model far (.ref_clk_in(ref_clk_in), .slow_in(slow), .rpt_word_in(rpt_word_out),
      .rpt_valid_in(rpt_valid_out), .rpt_last_in(rpt_last_out),
      .rpt_dio_only_in(rpt_dio_only_out), .rpt_ready_out(rpt_ready_in));

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge ref_clk_in);
      wr_in <= 1'b0;
   endtask

   task automatic reg_get(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge ref_clk_in);
      rd_in <= 1'b0;
      #1;
      d = rdata_out;
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] d;
      reg_get(a, d);
      chk(d, exp, what);
   endtask

   task automatic rx(input logic lng, input logic [63:0] src, input dsco_byte_t lv);
      @(posedge ref_clk_in);
      rx_valid_in <= 1'b1;
      rx_long_in <= lng;
      rx_src_in <= src;
      rx_levels_in <= lv;
      @(posedge ref_clk_in);
      rx_valid_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      #1;
   endtask

   task automatic wait_words(input int n);
      int i;
      for (i = 0; i < 400 && far.log_q.size() < n; i++)
         @(posedge ref_clk_in);
      #1;
      chk(far.log_q.size() >= n, 1, "report word count");
   endtask

   task automatic t_reset();
      reg_rd(8'h0C, 32'h0, "change mask reset");
      reg_rd(8'h00, 32'hFFFF_FFFF, "bound address reset");
      reg_rd(8'h3C, 32'h0, "unmapped read");
      chk(dio_oe_out, 8'h00, "oe after reset");
   endtask

   task automatic t_bound();
      reg_wr(8'h14, 32'hFF);
      rx(1'b1, 64'hFFFF_FFFF_FFFF_FFFF, 8'hA5);
      chk(dio_out, 8'h00, "all ones blocks");
      reg_rd(8'h24, 32'h4, "reject status");
      reg_wr(8'h00, 32'h89AB_CDEF);
      reg_wr(8'h04, 32'h0123_4567);
      reg_rd(8'h04, 32'h0123_4567, "long high word");
      rx(1'b1, 64'h0123_4567_89AB_CDEE, 8'h5A);
      chk(dio_out, 8'h00, "long mismatch");
      rx(1'b1, 64'h0123_4567_89AB_CDEF, 8'h5A);
      chk(dio_out, 8'h5A, "long match");
      reg_wr(8'h08, 32'h0);
      reg_wr(8'h00, 32'h1234);
      rx(1'b0, 64'h1235, 8'h33);
      chk(dio_out, 8'h5A, "short mismatch");
      rx(1'b0, 64'h1234, 8'h33);
      chk(dio_out, 8'h33, "short match");
      reg_wr(8'h00, 32'hFFFF);
      rx(1'b0, 64'hBEEF, 8'hC3);
      chk(dio_out, 8'hC3, "any sender");
      reg_wr(8'h24, 32'hF);
   endtask

   task automatic t_levels();
      reg_wr(8'h10, 32'hFF);
      reg_wr(8'h14, 32'h0F);
      repeat (3) @(posedge ref_clk_in);
      #1;
      chk(dio_out, 8'h0F, "level on outputs only");
      chk(dio_oe_out, 8'h0F, "enables follow direction");
      clk_en_in <= 1'b0;
      reg_wr(8'h10, 32'h00);
      clk_en_in <= 1'b1;
      reg_rd(8'h10, 32'hFF, "write lost while frozen");
      reg_wr(8'h14, 32'h0);
   endtask

   task automatic t_change();
      reg_wr(8'h30, 32'h1);
      adc_in <= 10'h2A5;
      reg_wr(8'h0C, 32'h01);
      dio_in <= 8'h02;
      repeat (20) @(posedge ref_clk_in);
      chk(far.log_q.size(), 0, "unwatched line");
      dio_in <= 8'h03;
      wait_words(1);
      chk(far.log_q.pop_front(), {2'b11, 10'h000, 8'h03}, "change word");
      chk(irq_out, 1'b0, "masked irq");
      reg_rd(8'h24, 32'h9, "change and report status");
      reg_rd(8'h20, 32'h3, "pin state");
      reg_wr(8'h28, 32'h1);
      repeat (2) @(posedge ref_clk_in);
      #1;
      chk(irq_out, 1'b1, "irq unmasked");
      reg_wr(8'h24, 32'h1);
      repeat (2) @(posedge ref_clk_in);
      #1;
      chk(irq_out, 1'b0, "irq cleared");
   endtask

   task automatic t_sample();
      slow <= 1'b1;
      reg_wr(8'h1C, 32'h2);
      // Ten ms with two samples a report keeps reports 20 ms apart
      reg_wr(8'h18, 32'hA);
      wait_words(2);
      reg_wr(8'h18, 32'h0);
      chk(far.log_q.pop_front(), {2'b00, 10'h2A5, 8'h03}, "first sample");
      chk(far.log_q.pop_front(), {2'b01, 10'h2A5, 8'h03}, "last sample");
      repeat (250) @(posedge ref_clk_in);
      chk(far.log_q.size(), 0, "interval zero stops");
      reg_rd(8'h2C, 32'h0, "queue stays empty");
      reg_wr(8'h18, 32'h0001_FFFF);
      reg_rd(8'h18, 32'hFFFF, "interval width");
      reg_wr(8'h18, 32'h0);
   endtask

   task automatic t_order();
      logic [31:0] q;
      int i;
      int n;
      reg_wr(8'h1C, 32'h3);
      reg_wr(8'h18, 32'h1);
      q = 0;
      for (i = 0; i < 40 && q[5:0] == 0; i++)
         reg_get(8'h2C, q);
      reg_wr(8'h18, 32'h0);
      reg_get(8'h2C, q);
      n = q[5:0];
      chk(n >= 1 && n < 3, 1, "samples queued");
      dio_in <= 8'h02;
      wait_words(n + 1);
      for (i = 0; i < n; i++)
         chk(far.log_q.pop_front(), {1'b0, i == n - 1, 10'h2A5, 8'h03}, "queued first");
      chk(far.log_q.pop_front(), {2'b11, 10'h000, 8'h02}, "change after queue");
   endtask

   initial
   begin
      repeat (3) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      t_reset();
      t_bound();
      t_levels();
      t_change();
      t_sample();
      t_order();
      complete_run();
   end

   // Whole run is under a thousand cycles; this span of 10000 cycles is far beyond it
   initial
   begin
      #400000;
      mismatches++;
      complete_run();
   end
endmodule
